// ==== src/enc_pkg.sv ====
package enc_pkg;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int GATE_1S_MS = 1000;
  localparam int GATE_100_MS = 100;
  localparam int GATE_10_MS = 10;
  localparam int CYC_1S = CLK_HZ / 1000 * GATE_1S_MS;
  localparam int CYC_100MS = CLK_HZ / 1000 * GATE_100_MS;
  localparam int CYC_10MS = CLK_HZ / 1000 * GATE_10_MS;
  localparam int SEC_PER_MIN = 60;
  localparam int STEPS_REV_LOG2 = 12;
  // parameter byte numbers and positions inside the extended block
  localparam logic [5:0] PRM_BASIS = 6'h1a;
  localparam logic [5:0] PRM_EXT_FIRST = 6'h1b;
  localparam logic [5:0] PRM_EXT_LAST = 6'h27;
  localparam int EXT_BYTES = 13;
  localparam int EXT_LOW = 0;
  localparam int EXT_UP = 4;
  localparam int EXT_IMP = 8;
  localparam int EXT_CFG = 12;
  // byte 26 bits
  localparam int B26_BASIS0 = 0;
  localparam int B26_BASIS1 = 1;
  localparam int B26_COMM = 2;
  localparam int B26_LOW_EN = 5;
  localparam int B26_UP_EN = 6;
  localparam int B26_EXT_EN = 7;
  // byte 39 bits
  localparam int B39_TYPE = 1;
  localparam int B39_TB0 = 4;
  localparam int B39_TB1 = 5;
  // input word layout
  localparam int POS_W = 25;
  localparam int ST_READY = 25;
  localparam int ST_MODE = 26;
  localparam int ST_LIMIT = 27;
  localparam int ST_DIR = 28;
  localparam logic [31:0] POS_LIMIT = 32'h02000000;
  localparam int PRESET_BIT = 31;
  // software registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_UNITS = 8'h04;
  localparam logic [7:0] REG_POSWORD = 8'h08;
  localparam logic [7:0] REG_SPEED = 8'h0c;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [31:0] UNITS_RST = 32'h00000001;

  typedef enum logic [1:0] {
    TB_SEC = 2'h0,
    TB_100MS = 2'h1,
    TB_10MS = 2'h2,
    TB_RPM = 2'h3
  } tbase_e;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic we;
    logic [5:0] idx;
    logic [7:0] data;
  } prm_wr_s;
endpackage : enc_pkg

// ==== src/pos_scaler.sv ====
`timescale 1ns/100ps
`default_nettype none
module pos_scaler #(
  parameter int POS_W = 25
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // async reset, low
  input wire logic up, // one raw step forward
  input wire logic dn, // one raw step back
  input wire logic phys_mode, // fractional scaling on
  input wire logic [31:0] units, // output steps per span
  input wire logic [31:0] phys, // raw steps per span
  input wire logic [POS_W-1:0] mask, // wrap mask
  input wire logic load, // preset strobe
  input wire logic [POS_W-1:0] load_val, // preset value
  output logic [POS_W-1:0] pos // scaled position
);
  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic [31:0] acc;
  } sc_s;
  sc_s cur, nxt;

  // remainder accumulator; assumes units not above phys
  always_comb begin
    logic [32:0] s;
    s = {1'b0, cur.acc} + {1'b0, units};
    nxt = cur;
    if (load) begin
      nxt.pos = load_val;
      nxt.acc = 32'h0;
    end else if (up) begin
      if (phys_mode) begin
        if (s >= {1'b0, phys}) begin
          nxt.pos = cur.pos + 1'b1;
          nxt.acc = 32'(s - {1'b0, phys});
        end else begin
          nxt.acc = s[31:0];
        end
      end else begin
        nxt.pos = cur.pos + 1'b1;
      end
    end else if (dn) begin
      if (phys_mode) begin
        if (cur.acc >= units) begin
          nxt.acc = cur.acc - units;
        end else begin
          nxt.pos = cur.pos - 1'b1;
          nxt.acc = cur.acc + phys - units;
        end
      end else begin
        nxt.pos = cur.pos - 1'b1;
      end
    end
    nxt.pos = nxt.pos & mask;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign pos = cur.pos;
endmodule : pos_scaler
`default_nettype wire

// ==== src/speed_meter.sv ====
`timescale 1ns/100ps
`default_nettype none
module speed_meter #(
  parameter int CYC_1S = enc_pkg::CYC_1S,
  parameter int CYC_100MS = enc_pkg::CYC_100MS,
  parameter int CYC_10MS = enc_pkg::CYC_10MS
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // async reset, low
  input wire logic up, // step forward
  input wire logic dn, // step back
  input wire enc_pkg::tbase_e tb, // time base
  output logic [15:0] speed // signed speed
);
  typedef struct packed {
    logic [23:0] gate;
    logic [23:0] cnt;
    logic [15:0] speed;
  } sm_s;
  sm_s cur, nxt;

  // gate length follows the time base; rpm uses the one second gate
  always_comb begin
    logic [23:0] last;
    logic [23:0] cnt_n;
    logic [31:0] rpm;
    last = 24'(CYC_1S - 1);
    cnt_n = 24'h0;
    rpm = 32'h0;
    unique case (tb)
      enc_pkg::TB_100MS: last = 24'(CYC_100MS - 1);
      enc_pkg::TB_10MS: last = 24'(CYC_10MS - 1);
      enc_pkg::TB_SEC, enc_pkg::TB_RPM: last = 24'(CYC_1S - 1);
    endcase
    cnt_n = cur.cnt + {23'h0, up} - {23'h0, dn};
    rpm = 32'(($signed(32'(signed'(cnt_n))) * enc_pkg::SEC_PER_MIN)
      >>> enc_pkg::STEPS_REV_LOG2);
    nxt = cur;
    nxt.gate = cur.gate + 24'h1;
    nxt.cnt = cnt_n;
    if (cur.gate >= last) begin
      nxt.gate = 24'h0;
      nxt.cnt = 24'h0;
      nxt.speed = (tb == enc_pkg::TB_RPM) ? rpm[15:0] : cnt_n[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign speed = cur.speed;
endmodule : speed_meter
`default_nettype wire

// ==== src/encoder_param_and_data_exchange.sv ====
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module encoder_param_and_data_exchange #(
  parameter int CYC_1S = enc_pkg::CYC_1S,
  parameter int CYC_100MS = enc_pkg::CYC_100MS,
  parameter int CYC_10MS = enc_pkg::CYC_10MS,
  parameter int STEPS_REV_LOG2 = enc_pkg::STEPS_REV_LOG2
) (
  input wire logic ref_clk, // clock, 10 MHz
  input wire logic nrst, // async reset, low
  input wire enc_pkg::bus_req_s bus, // register access
  output logic [31:0] rdata, // read data, cycle after read
  input wire enc_pkg::prm_wr_s prm, // parameter byte write
  input wire logic prm_done, // parameter telegram complete
  input wire logic step_up, // raw disk step clockwise
  input wire logic step_dn, // raw disk step anticlockwise
  input wire logic data_req, // master asks for input data
  input wire logic out_valid, // master output word valid
  input wire logic [31:0] out_word, // master output word
  output logic [31:0] in_word, // position word to master
  output logic [15:0] in_speed, // speed word to master
  output logic in_valid // input words fresh
);
  localparam int PW = enc_pkg::POS_W;

  typedef struct packed {
    logic [enc_pkg::EXT_BYTES-1:0][7:0] ext;
    logic [7:0] b26;
    logic [enc_pkg::EXT_BYTES-1:0][7:0] ext_act;
    logic [7:0] b26_act;
    logic ready;
    logic dir;
    logic [31:0] units;
    logic [31:0] in_word;
    logic [15:0] in_speed;
    logic in_valid;
    logic [31:0] rdata;
  } core_s;
  core_s cur, nxt;

  logic [31:0] phys;
  logic [31:0] lower;
  logic [31:0] upper;
  logic [7:0] cfg39;
  logic phys_mode;
  logic commission;
  logic limit;
  logic up;
  logic dn;
  logic [PW-1:0] mask;
  logic [PW-1:0] pos;
  logic [15:0] speed;
  logic [31:0] word;
  enc_pkg::tbase_e tb;

  // decode of the applied parameter set
  assign phys = {cur.ext_act[enc_pkg::EXT_IMP], cur.ext_act[enc_pkg::EXT_IMP+1],
    cur.ext_act[enc_pkg::EXT_IMP+2], cur.ext_act[enc_pkg::EXT_IMP+3]};
  assign lower = {cur.ext_act[enc_pkg::EXT_LOW], cur.ext_act[enc_pkg::EXT_LOW+1],
    cur.ext_act[enc_pkg::EXT_LOW+2], cur.ext_act[enc_pkg::EXT_LOW+3]};
  assign upper = {cur.ext_act[enc_pkg::EXT_UP], cur.ext_act[enc_pkg::EXT_UP+1],
    cur.ext_act[enc_pkg::EXT_UP+2], cur.ext_act[enc_pkg::EXT_UP+3]};
  assign cfg39 = cur.ext_act[enc_pkg::EXT_CFG];
  // zero impulse count would divide by nothing, so it falls back to raw steps
  assign phys_mode = !cur.b26_act[enc_pkg::B26_BASIS0] && cur.b26_act[enc_pkg::B26_BASIS1]
    && (phys != 32'h0);
  assign commission = cur.b26_act[enc_pkg::B26_COMM];
  assign tb = enc_pkg::tbase_e'({cfg39[enc_pkg::B39_TB1], cfg39[enc_pkg::B39_TB0]});
  // single-turn wraps every revolution
  assign mask = cfg39[enc_pkg::B39_TYPE] ? {PW{1'b1}}
    : PW'((33'h1 << STEPS_REV_LOG2) - 33'h1);
  // counting direction swaps the raw steps before scaling
  assign up = cur.dir ? step_dn : step_up;
  assign dn = cur.dir ? step_up : step_dn;
  // a disabled limit never flags
  assign limit = (cur.b26_act[enc_pkg::B26_UP_EN] && ({7'h0, pos} > upper))
    || (cur.b26_act[enc_pkg::B26_LOW_EN] && ({7'h0, pos} < lower));

  // assembled input word; status bits fill bits 25 to 28, above the 25-bit position
  always_comb begin
    word = {7'h0, pos};
    word[enc_pkg::ST_READY] = cur.ready;
    word[enc_pkg::ST_MODE] = !commission;
    word[enc_pkg::ST_LIMIT] = limit;
    word[enc_pkg::ST_DIR] = cur.dir;
  end

  pos_scaler #(
    .POS_W(PW)
  ) u_scaler (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .up(up),
    .dn(dn),
    .phys_mode(phys_mode),
    .units(cur.units),
    .phys(phys),
    .mask(mask),
    .load(out_valid && out_word[enc_pkg::PRESET_BIT]),
    .load_val(out_word[PW-1:0]),
    .pos(pos)
  );

  speed_meter #(
    .CYC_1S(CYC_1S),
    .CYC_100MS(CYC_100MS),
    .CYC_10MS(CYC_10MS)
  ) u_speed (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .up(up),
    .dn(dn),
    .tb(tb),
    .speed(speed)
  );

  // parameter capture, register bus and cyclic answer
  always_comb begin
    logic [5:0] off;
    off = prm.idx - enc_pkg::PRM_EXT_FIRST;
    nxt = cur;
    if (prm.we) begin
      if (prm.idx == enc_pkg::PRM_BASIS) begin
        nxt.b26 = prm.data;
      end else if (prm.idx >= enc_pkg::PRM_EXT_FIRST && prm.idx <= enc_pkg::PRM_EXT_LAST) begin
        nxt.ext[off[3:0]] = prm.data;
      end
    end
    // the set only takes effect as a whole, at the end of the telegram
    if (prm_done) begin
      nxt.b26_act = cur.b26;
      nxt.ext_act = cur.b26[enc_pkg::B26_EXT_EN] ? cur.ext : '0;
      nxt.ready = 1'b1;
    end
    if (bus.we) begin
      if (bus.addr == enc_pkg::REG_CTRL) begin
        nxt.dir = bus.wdata[0];
      end else if (bus.addr == enc_pkg::REG_UNITS) begin
        nxt.units = bus.wdata;
      end
    end
    nxt.rdata = 32'h0;
    if (bus.re) begin
      unique case (bus.addr)
        enc_pkg::REG_CTRL: nxt.rdata = {31'h0, cur.dir};
        enc_pkg::REG_UNITS: nxt.rdata = cur.units;
        enc_pkg::REG_POSWORD: nxt.rdata = word;
        enc_pkg::REG_SPEED: nxt.rdata = {16'h0, speed};
        default: nxt.rdata = 32'h0;
      endcase
    end
    nxt.in_valid = 1'b0;
    if (data_req) begin
      nxt.in_word = word;
      nxt.in_speed = speed;
      nxt.in_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.dir <= enc_pkg::CTRL_RST;
      cur.units <= enc_pkg::UNITS_RST;
    end else begin
      cur <= nxt;
    end
  end

  assign rdata = cur.rdata;
  assign in_word = cur.in_word;
  assign in_speed = cur.in_speed;
  assign in_valid = cur.in_valid;

  // checks
  AST_EXT_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst)
    prm_done && !cur.b26[enc_pkg::B26_EXT_EN] |=> cur.ext_act == '0)
    else $error("extended bytes applied while disabled");
  AST_IMP_ORDER: assert property (@(posedge ref_clk) disable iff (!nrst)
    prm_done && cur.b26[enc_pkg::B26_EXT_EN] |=>
    phys == {$past(cur.ext[enc_pkg::EXT_IMP]), $past(cur.ext[enc_pkg::EXT_IMP+1]),
    $past(cur.ext[enc_pkg::EXT_IMP+2]), $past(cur.ext[enc_pkg::EXT_IMP+3])})
    else $error("impulse count byte order wrong");
  AST_BASIS: assert property (@(posedge ref_clk) disable iff (!nrst)
    phys_mode |-> !cur.b26_act[enc_pkg::B26_BASIS0] && cur.b26_act[enc_pkg::B26_BASIS1])
    else $error("impulse scaling outside its basis");
  AST_REQ_ANSWER: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req |=> in_valid && in_word[PW-1:0] == $past(pos))
    else $error("request not answered with position");
  AST_PRESET: assert property (@(posedge ref_clk) disable iff (!nrst)
    out_valid && out_word[enc_pkg::PRESET_BIT] |=> pos == ($past(out_word[PW-1:0]) & $past(mask)))
    else $error("preset not taken");
  AST_STATUS: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req |=> in_word[enc_pkg::ST_READY] == $past(cur.ready)
    && in_word[enc_pkg::ST_MODE] == !$past(commission))
    else $error("ready or mode flag wrong");
  AST_DIR_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req |=> in_word[enc_pkg::ST_DIR] == $past(cur.dir))
    else $error("direction flag wrong");
  AST_LIMIT_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req && cur.b26_act[enc_pkg::B26_UP_EN] && ({7'h0, pos} > upper)
    |=> in_word[enc_pkg::ST_LIMIT])
    else $error("limit flag missed above upper limit");
  AST_HIGH_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
    in_valid |-> in_word[31:29] == 3'h0)
    else $error("top status bits not zero");
  AST_SPEED_WORD: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req |=> in_speed == $past(speed))
    else $error("speed word stale");
  // the wrap mask needs one cycle after a type change to trim the position
  AST_SINGLE_TURN: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfg39[enc_pkg::B39_TYPE] && !$past(cfg39[enc_pkg::B39_TYPE])
    |-> ({7'h0, pos} >> STEPS_REV_LOG2) == 32'h0)
    else $error("single-turn position beyond one revolution");

  // parameter application
  AST_EXT_APPLIED: assert property (@(posedge ref_clk) disable iff (!nrst)
    prm_done && cur.b26[enc_pkg::B26_EXT_EN] |=> cur.ext_act == $past(cur.ext))
    else $error("extended bytes not applied while enabled");
  AST_EXT_HELD: assert property (@(posedge ref_clk) disable iff (!nrst)
    !prm_done |=> $stable(cur.ext_act) && $stable(cur.b26_act))
    else $error("applied set changed without telegram end");
  AST_BASIS_ON: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cur.b26_act[enc_pkg::B26_BASIS0] && cur.b26_act[enc_pkg::B26_BASIS1]
    && phys != 32'h0 |-> phys_mode)
    else $error("impulse basis not taken");
  AST_READY_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
    prm_done |=> cur.ready)
    else $error("ready not set after parameters");
  AST_READY_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    cur.ready |=> cur.ready)
    else $error("ready dropped");

  // scaling and counting direction
  AST_PHYS_STEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    phys_mode && up && !dn && !(out_valid && out_word[enc_pkg::PRESET_BIT])
    |=> pos == ($past(pos) & $past(mask)) || pos == (PW'($past(pos) + 1'b1) & $past(mask)))
    else $error("impulse scaling moved more than one step");
  AST_RAW_UP: assert property (@(posedge ref_clk) disable iff (!nrst)
    !phys_mode && up && !dn && !(out_valid && out_word[enc_pkg::PRESET_BIT])
    |=> pos == (PW'($past(pos) + 1'b1) & $past(mask)))
    else $error("raw step forward lost");
  AST_RAW_DOWN: assert property (@(posedge ref_clk) disable iff (!nrst)
    !phys_mode && dn && !up && !(out_valid && out_word[enc_pkg::PRESET_BIT])
    |=> pos == (PW'($past(pos) - 1'b1) & $past(mask)))
    else $error("raw step back lost");
  AST_PRESET_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst)
    out_valid && !out_word[enc_pkg::PRESET_BIT] && !up && !dn
    |=> pos == ($past(pos) & $past(mask)))
    else $error("output word without preset bit moved position");
  AST_MULTI_MASK: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg39[enc_pkg::B39_TYPE] |-> mask == {PW{1'b1}})
    else $error("multi-turn range cut");
  AST_SINGLE_MASK: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfg39[enc_pkg::B39_TYPE] |-> mask == PW'((1 << STEPS_REV_LOG2) - 1))
    else $error("single-turn wrap wrong");
  AST_DIR_SWAP: assert property (@(posedge ref_clk) disable iff (!nrst)
    cur.dir |-> up == step_dn && dn == step_up)
    else $error("anticlockwise counting not swapped");
  AST_DIR_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cur.dir |-> up == step_up && dn == step_dn)
    else $error("clockwise counting swapped");

  // time base decode
  AST_TB_SEC: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfg39[enc_pkg::B39_TB0] && !cfg39[enc_pkg::B39_TB1] |-> tb == enc_pkg::TB_SEC)
    else $error("seconds base not chosen");
  AST_TB_100MS: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg39[enc_pkg::B39_TB0] && !cfg39[enc_pkg::B39_TB1] |-> tb == enc_pkg::TB_100MS)
    else $error("100 ms base not chosen");
  AST_TB_10MS: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cfg39[enc_pkg::B39_TB0] && cfg39[enc_pkg::B39_TB1] |-> tb == enc_pkg::TB_10MS)
    else $error("10 ms base not chosen");
  AST_TB_RPM: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg39[enc_pkg::B39_TB0] && cfg39[enc_pkg::B39_TB1] |-> tb == enc_pkg::TB_RPM)
    else $error("rpm base not chosen");

  // status word
  AST_MODE_BIT: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req |=> in_word[enc_pkg::ST_MODE] == !$past(cur.b26_act[enc_pkg::B26_COMM]))
    else $error("mode flag misplaced");
  AST_LIMIT_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req && cur.b26_act[enc_pkg::B26_LOW_EN] && ({7'h0, pos} < lower)
    |=> in_word[enc_pkg::ST_LIMIT])
    else $error("limit flag missed below lower limit");
  AST_LIMIT_IN: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_req && (!cur.b26_act[enc_pkg::B26_UP_EN] || ({7'h0, pos} <= upper))
    && (!cur.b26_act[enc_pkg::B26_LOW_EN] || ({7'h0, pos} >= lower))
    |=> !in_word[enc_pkg::ST_LIMIT])
    else $error("limit flag set inside window");

  // cyclic exchange and register bus
  AST_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
    !data_req |=> !in_valid)
    else $error("answer without request");
  AST_WORD_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
    !data_req |=> $stable(in_word) && $stable(in_speed))
    else $error("input words moved between requests");
  AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!nrst)
    !bus.re |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_RD_WORD: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus.re && bus.addr == enc_pkg::REG_POSWORD |=> rdata == $past(word))
    else $error("position word read wrong");
  AST_RD_UNITS: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus.re && bus.addr == enc_pkg::REG_UNITS |=> rdata == $past(cur.units))
    else $error("units read wrong");
  AST_WR_RO: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus.we && bus.addr == enc_pkg::REG_POSWORD |=> $stable(cur.units) && $stable(cur.dir))
    else $error("read-only write changed state");

  // coverage of the main scenarios
  COV_EXT_ON: cover property (@(posedge ref_clk) disable iff (!nrst)
    prm_done && cur.b26[enc_pkg::B26_EXT_EN]);
  COV_PHYS_STEP: cover property (@(posedge ref_clk) disable iff (!nrst)
    phys_mode && up ##1 $changed(pos));
  COV_PRESET: cover property (@(posedge ref_clk) disable iff (!nrst)
    out_valid && out_word[enc_pkg::PRESET_BIT] ##1 data_req);
  COV_RPM: cover property (@(posedge ref_clk) disable iff (!nrst)
    tb == enc_pkg::TB_RPM && in_valid);
  COV_LIMIT: cover property (@(posedge ref_clk) disable iff (!nrst)
    in_valid && in_word[enc_pkg::ST_LIMIT]);
endmodule : encoder_param_and_data_exchange
`default_nettype wire

// ==== tb/fieldbus_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master (
  input wire logic ref_clk, // clock
  input wire logic in_valid, // input words fresh
  input wire logic [31:0] in_word, // position word
  input wire logic [15:0] in_speed, // speed word
  output logic data_req, // ask for input words
  output logic out_valid, // output word valid
  output logic [31:0] out_word // output word
);
  // idle bus from time zero
  initial begin
    data_req = 1'b0;
    out_valid = 1'b0;
    out_word = 32'h00000000;
  end

  // one request; the answer is only taken in the cycle after it
  task automatic poll(output logic [31:0] w, output logic [15:0] s, output logic ok);
    @(posedge ref_clk);
    data_req <= 1'b1;
    @(posedge ref_clk);
    data_req <= 1'b0;
    #1;
    ok = in_valid;
    w = in_word;
    s = in_speed;
  endtask : poll

  // released word turns to its inverse so a stale value cannot pass
  task automatic send(input logic [31:0] word);
    @(posedge ref_clk);
    out_valid <= 1'b1;
    out_word <= word;
    @(posedge ref_clk);
    out_valid <= 1'b0;
    out_word <= ~word;
  endtask : send
endmodule : fieldbus_master
`default_nettype wire

// ==== tb/encoder_param_and_data_exchange_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module encoder_param_and_data_exchange_tb;
  logic ref_clk, nrst, prm_done, step_up, step_dn, data_req, out_valid, in_valid, ok;
  enc_pkg::bus_req_s bus;
  enc_pkg::prm_wr_s prm;
  logic [31:0] rdata, out_word, in_word, w, r;
  logic [15:0] in_speed, s;
  logic [7:0] ext [13];
  logic [24:0] lim_pos [4] = '{25'h1, 25'h2, 25'h4, 25'h5};
  logic [3:0] lim_out = 4'b1001;
  logic [15:0] sp_exp [5] = '{16'h0064, 16'h000a, 16'h0005, 16'h0001, 16'hff9c};
  int n_mismatch, compares;

  // short gates keep the speed runs brief
  encoder_param_and_data_exchange #(.CYC_1S(100), .CYC_100MS(10), .CYC_10MS(5),
      .STEPS_REV_LOG2(12)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .prm(prm), .prm_done(prm_done), .step_up(step_up), .step_dn(step_dn),
      .data_req(data_req), .out_valid(out_valid), .out_word(out_word), .in_word(in_word),
      .in_speed(in_speed), .in_valid(in_valid));

  fieldbus_master u_master (.ref_clk(ref_clk), .in_valid(in_valid), .in_word(in_word),
      .in_speed(in_speed), .data_req(data_req), .out_valid(out_valid), .out_word(out_word));

  always #50 ref_clk = ~ref_clk;

  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h00000000};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  // byte 26, then the whole extended block, then apply
  task automatic prm_set(input logic [7:0] b26);
    @(posedge ref_clk);
    prm <= '{we: 1'b1, idx: enc_pkg::PRM_BASIS, data: b26};
    for (int i = 0; i < enc_pkg::EXT_BYTES; i++) begin
      @(posedge ref_clk);
      prm <= '{we: 1'b1, idx: enc_pkg::PRM_EXT_FIRST + 6'(i), data: ext[i]};
    end
    @(posedge ref_clk);
    prm <= '0;
    prm_done <= 1'b1;
    @(posedge ref_clk);
    prm_done <= 1'b0;
  endtask : prm_set

  task automatic up(input int n);
    @(posedge ref_clk);
    step_up <= 1'b1;
    repeat (n) @(posedge ref_clk);
    step_up <= 1'b0;
  endtask : up

  task automatic see(input logic [31:0] e);
    u_master.poll(w, s, ok);
    `CHK(ok, 1'b1, "no answer")
    `CHK(w, e, "input word")
  endtask : see

  task automatic preset(input logic [24:0] v);
    u_master.send({1'b1, 6'h00, v});
  endtask : preset

  // ready and normal mode set, bits 31..29 clear
  function automatic logic [31:0] ew(input logic lim, input logic dir, input logic [24:0] p);
    return {3'h0, dir, lim, 2'b11, p};
  endfunction : ew

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    bus = '0;
    prm = '0;
    prm_done = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    ext = '{default: 8'h00};
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    see(32'h04000000);
    rd(enc_pkg::REG_UNITS, r);
    `CHK(r, enc_pkg::UNITS_RST, "units reset")
    rd(8'h40, r);
    `CHK(r, 32'h00000000, "unmapped read")
    wr(enc_pkg::REG_POSWORD, 32'hffffffff);
    rd(enc_pkg::REG_POSWORD, r);
    `CHK(r, 32'h04000000, "read-only word")
    prm_set(8'h04);
    see(32'h02000000);
    prm_set(8'h00);
    up(3);
    see(ew(1'b0, 1'b0, 25'h3));
    // reversed counting: a forward step now counts down
    wr(enc_pkg::REG_CTRL, 32'h00000001);
    rd(enc_pkg::REG_CTRL, r);
    `CHK(r[0], 1'b1, "ctrl readback")
    up(1);
    see(ew(1'b0, 1'b1, 25'h2));
    wr(enc_pkg::REG_CTRL, 32'h00000000);
    // 2 units per 3 raw steps, first with the block disabled
    ext[11] = 8'h03;
    wr(enc_pkg::REG_UNITS, 32'h00000002);
    prm_set(8'h02);
    up(3);
    see(ew(1'b0, 1'b0, 25'h5));
    prm_set(8'h82);
    preset(25'h0);
    up(3);
    see(ew(1'b0, 1'b0, 25'h2));
    prm_set(8'h81);
    up(3);
    see(ew(1'b0, 1'b0, 25'h5));
    wr(enc_pkg::REG_UNITS, 32'h00000001);
    // limit window 2..4, both ends enabled
    ext = '{default: 8'h00};
    ext[3] = 8'h02;
    ext[7] = 8'h04;
    prm_set(8'he0);
    for (int i = 0; i < 4; i++) begin
      preset(lim_pos[i]);
      see(ew(lim_out[i], 1'b0, lim_pos[i]));
    end
    // multi-turn: full 25-bit range, wraps past the top
    ext = '{default: 8'h00};
    ext[12] = 8'h02;
    prm_set(8'h80);
    preset(25'h1ffffff);
    see(ew(1'b0, 1'b0, 25'h1ffffff));
    up(1);
    see(ew(1'b0, 1'b0, 25'h0));
    u_master.send(32'h00000005);
    see(ew(1'b0, 1'b0, 25'h0));
    ext[12] = 8'h00;
    prm_set(8'h80);
    preset(25'h1ffffff);
    see(ew(1'b0, 1'b0, 25'h0fff));
    // steady stepping over several gates in each time base, then backwards
    for (int i = 0; i < 5; i++) begin
      ext[12] = 8'((i % 4) << 4);
      prm_set(8'h80);
      @(posedge ref_clk);
      step_up <= (i < 4);
      step_dn <= (i == 4);
      repeat (260) @(posedge ref_clk);
      u_master.poll(w, s, ok);
      `CHK(s, sp_exp[i], "speed word")
      rd(enc_pkg::REG_SPEED, r);
      `CHK(r[15:0], sp_exp[i], "speed register")
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end
    complete_run();
  end
endmodule : encoder_param_and_data_exchange_tb
`default_nettype wire
